// File: rtl/cefu_defines.svh
// Constants and fixed encodings for the exception frame unit
// Contract
// - Reset fetches stack pointer vector 0, counter 1
// - Fault-type exceptions stack faulting instruction address
// - Next-type exceptions stack following instruction address
// - Trap n uses vector 32 plus n
// - Autovector levels 1-7 map to 25-31
// - No interrupt sampling in handler first instruction
// - Frame is two longwords: format/vector/status, counter
// - Format encodes stack pointer low bits, 4 to 7
// - Fault status zero except access/address errors
// - Codes: fetch 0100, write 1000, read 1100
// - Write-protected space reports code 1001
// - Interrupt vector equals peripheral-supplied value; code substitutes spurious vector 24 for values below 64
// - Bus error raises access error, vector 2
// - Fetch errors deferred; discarded prefetch faults ignored
// - Faulted opword aborts, programming model unchanged
// - Operand read error aborts, address updates kept
// - Partial multi-register load keeps loaded registers
// - Write errors imprecise; writer's updates complete
// - No-operation sync waits writes, reports their error
// - Vector address is base plus four times number
// - Vector base keeps only upper 12 bits
// - Entry sets supervisor, clears trace; interrupts set mask
`ifndef CEFU_DEFINES_SVH
`define CEFU_DEFINES_SVH
`define CEFU_VEC_RESET_SP 8'h00
`define CEFU_VEC_RESET_PC 8'h01
`define CEFU_VEC_ACCESS 8'h02
`define CEFU_VEC_ADDRESS 8'h03
`define CEFU_VEC_ILLEGAL 8'h04
`define CEFU_VEC_PRIV 8'h08
`define CEFU_VEC_TRACE 8'h09
`define CEFU_VEC_LINE_A 8'h0A
`define CEFU_VEC_LINE_F 8'h0B
`define CEFU_VEC_DEBUG 8'h0C
`define CEFU_VEC_FORMAT 8'h0E
`define CEFU_VEC_UNINIT 8'h0F
`define CEFU_VEC_SPURIOUS 8'h18
`define CEFU_VEC_AUTO_BASE 8'h18
`define CEFU_VEC_TRAP_BASE 8'h20
`define CEFU_VEC_USER_MIN 8'h40
`define CEFU_FS_NONE 4'h0
`define CEFU_FS_FETCH 4'h4
`define CEFU_FS_WRITE 4'h8
`define CEFU_FS_WPROT 4'h9
`define CEFU_FS_READ 4'hC
`define CEFU_FMT_BASE 4'h4
`define CEFU_FRAME_BYTES 32'h0000_0008
`define CEFU_SR_T 15
`define CEFU_SR_S 13
`define CEFU_SR_M 12
`define CEFU_SR_IMSK_HI 10
`define CEFU_SR_IMSK_LO 8
`define CEFU_VBR_KEEP 32'hFFF0_0000
`endif

// File: rtl/cefu_exception_unit.sv
// Exception entry, frame building, access-error and write-error handling
`timescale 1ns/1ps
`include "cefu_defines.svh"
module cefu_exception_unit (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_exc_req,
	input wire cefu_pkg::cefu_src_t i_exc_src,
	input wire logic [3:0] i_trap_num,
	input wire logic [3:0] i_addr_fs,
	input wire logic i_int_req,
	input wire logic [2:0] i_int_level,
	input wire cefu_pkg::cefu_int_kind_t i_int_kind,
	input wire logic [7:0] i_int_vector,
	input wire logic [31:0] i_fault_pc,
	input wire logic [31:0] i_next_pc,
	input wire logic [31:0] i_stack_pointer_register,
	input wire logic [15:0] i_status_register,
	input wire logic [31:0] i_vector_base_wdata,
	input wire logic i_vector_base_we,
	input wire logic i_fetch_err,
	input wire logic i_flow_change,
	input wire logic i_exec_faulted,
	input wire logic i_read_err,
	input wire logic i_write_err,
	input wire logic i_write_prot,
	input wire logic i_write_pending,
	input wire logic i_no_operation_sync,
	input wire logic i_insn_done,
	output logic o_exc_active,
	output logic [7:0] o_vector,
	output logic [31:0] o_vector_addr,
	output logic [31:0] o_frame_word0,
	output logic [31:0] o_frame_word1,
	output logic [31:0] o_frame_sp,
	output logic [15:0] o_status_register,
	output logic o_abort,
	output logic o_keep_addr_updates,
	output logic o_int_sample_en,
	output logic o_sync_stall,
	output logic [31:0] o_vector_base,
	output logic o_reset_fetch_sp,
	output logic o_reset_fetch_pc
);
	typedef enum logic [1:0] {
		CEFU_RUN,
		CEFU_BOOT_SP,
		CEFU_BOOT_PC
	} cefu_boot_t;

	cefu_boot_t boot_state;
	logic fetch_fault_pending;
	logic write_err_pending;
	logic [3:0] write_err_fs;
	logic handler_first;
	cefu_pkg::cefu_src_t sel_src;
	logic [3:0] sel_fs;
	logic [31:0] sel_pc;
	logic take;
	logic take_int;
	logic [7:0] map_vector;
	logic map_next;
	logic map_fs_ok;
	logic [1:0] sp_low;
	logic [31:0] sp_aligned;
	logic [15:0] next_sr;

	// Reset sequence: stack pointer entry, then program counter entry
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			boot_state <= CEFU_BOOT_SP;
		end else begin
			case (boot_state)
				CEFU_BOOT_SP: boot_state <= CEFU_BOOT_PC;
				CEFU_BOOT_PC: boot_state <= CEFU_RUN;
				default: boot_state <= CEFU_RUN;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_reset_fetch_sp <= 1'b0;
			o_reset_fetch_pc <= 1'b0;
		end else begin
			o_reset_fetch_sp <= (boot_state == CEFU_BOOT_SP);
			o_reset_fetch_pc <= (boot_state == CEFU_BOOT_PC);
		end
	end

	// Prefetch fault held until needed; a change of flow discards it
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			fetch_fault_pending <= 1'b0;
		end else if (i_fetch_err) begin
			fetch_fault_pending <= 1'b1;
		end else if (i_flow_change || take) begin
			fetch_fault_pending <= 1'b0;
		end
	end

	// Write errors collected; set wins over the report clear
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			write_err_pending <= 1'b0;
			write_err_fs <= `CEFU_FS_NONE;
		end else if (i_write_err) begin
			write_err_pending <= 1'b1;
			write_err_fs <= i_write_prot ? `CEFU_FS_WPROT : `CEFU_FS_WRITE;
		end else if (take && sel_src == cefu_pkg::CEFU_SRC_ACCESS && sel_fs == write_err_fs) begin
			write_err_pending <= 1'b0;
		end
	end

	// Source priority: read error, faulted execution, pending write, request
	always_comb begin
		sel_src = i_exc_src;
		sel_fs = `CEFU_FS_NONE;
		sel_pc = i_fault_pc;
		take = 1'b0;
		take_int = 1'b0;
		if (boot_state != CEFU_RUN || o_exc_active) begin
			take = 1'b0;
		end else if (i_read_err) begin
			sel_src = cefu_pkg::CEFU_SRC_ACCESS;
			sel_fs = `CEFU_FS_READ;
			take = 1'b1;
		end else if (i_exec_faulted && fetch_fault_pending) begin
			sel_src = cefu_pkg::CEFU_SRC_ACCESS;
			sel_fs = `CEFU_FS_FETCH;
			take = 1'b1;
		end else if (write_err_pending && (i_insn_done || (i_no_operation_sync && !i_write_pending))) begin
			sel_src = cefu_pkg::CEFU_SRC_ACCESS;
			sel_fs = write_err_fs;
			sel_pc = i_fault_pc;
			take = 1'b1;
		end else if (i_exc_req) begin
			sel_src = i_exc_src;
			sel_fs = (i_exc_src == cefu_pkg::CEFU_SRC_ADDRESS) ? i_addr_fs : `CEFU_FS_NONE;
			take = (i_exc_src != cefu_pkg::CEFU_SRC_NONE);
		end else if (i_int_req && o_int_sample_en) begin
			sel_src = cefu_pkg::CEFU_SRC_INTR;
			take = 1'b1;
			take_int = 1'b1;
		end
	end

	cefu_vector_map u_map (
		.i_src(sel_src),
		.i_trap_num(i_trap_num),
		.i_int_level(i_int_level),
		.i_int_kind(i_int_kind),
		.i_int_vector(i_int_vector),
		.o_vector(map_vector),
		.o_use_next_pc(map_next),
		.o_fs_allowed(map_fs_ok)
	);

	assign sp_low = i_stack_pointer_register[1:0];
	assign sp_aligned = {i_stack_pointer_register[31:2], 2'b00};

	always_comb begin
		next_sr = i_status_register;
		next_sr[`CEFU_SR_S] = 1'b1;
		next_sr[`CEFU_SR_T] = 1'b0;
		if (take_int) begin
			next_sr[`CEFU_SR_M] = 1'b0;
			next_sr[`CEFU_SR_IMSK_HI:`CEFU_SR_IMSK_LO] = i_int_level;
		end
	end

	// Vector base: only top 12 bits stored
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_vector_base <= 32'h0000_0000;
		end else if (i_vector_base_we) begin
			o_vector_base <= i_vector_base_wdata & `CEFU_VBR_KEEP;
		end
	end

	// Frame construction and entry outputs; strobes last one cycle, frame held until next entry
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_exc_active <= 1'b0;
			o_vector <= 8'h00;
			o_vector_addr <= 32'h0000_0000;
			o_frame_word0 <= 32'h0000_0000;
			o_frame_word1 <= 32'h0000_0000;
			o_frame_sp <= 32'h0000_0000;
			o_status_register <= 16'h0000;
			o_abort <= 1'b0;
			o_keep_addr_updates <= 1'b0;
		end else begin
			o_exc_active <= take;
			o_abort <= take && (sel_fs == `CEFU_FS_READ || sel_fs == `CEFU_FS_FETCH);
			o_keep_addr_updates <= take && sel_fs == `CEFU_FS_READ;
			if (take) begin
				o_vector <= map_vector;
				o_vector_addr <= (o_vector_base & `CEFU_VBR_KEEP) + {22'h00_0000, map_vector, 2'b00};
				o_frame_word0 <= {`CEFU_FMT_BASE | {2'b00, sp_low},
					map_fs_ok ? sel_fs[3:2] : 2'b00,
					map_vector,
					map_fs_ok ? sel_fs[1:0] : 2'b00,
					i_status_register};
				o_frame_word1 <= map_next ? i_next_pc : sel_pc;
				o_frame_sp <= sp_aligned - `CEFU_FRAME_BYTES;
				o_status_register <= next_sr;
			end
		end
	end

	// First handler instruction masks interrupt sampling
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			handler_first <= 1'b1;
		end else if (take) begin
			handler_first <= 1'b1;
		end else if (i_insn_done) begin
			handler_first <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_int_sample_en <= 1'b0;
			o_sync_stall <= 1'b0;
		end else begin
			o_int_sample_en <= !take && !(handler_first && !i_insn_done);
			o_sync_stall <= i_no_operation_sync && i_write_pending;
		end
	end

	AST_RESET_SEQ: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_reset_fetch_sp |=> o_reset_fetch_pc)
		else $error("pc fetch must follow sp fetch");
	AST_BUS_ERR_VEC: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(take && sel_fs != `CEFU_FS_NONE && sel_src == cefu_pkg::CEFU_SRC_ACCESS)
		|=> o_vector == `CEFU_VEC_ACCESS)
		else $error("access error not vector 2");
	AST_VEC_ADDR: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_exc_active |-> o_vector_addr[9:0] == {o_vector, 2'b00})
		else $error("vector address mismatch");
	AST_VBR_LOW: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_vector_base[19:0] == 20'h0_0000)
		else $error("vector base low bits set");
	AST_FORMAT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		take |=> o_frame_word0[31:28] == {2'b01, $past(sp_low)})
		else $error("bad format field");
	AST_FS_ZERO: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(take && !map_fs_ok) |=> {o_frame_word0[27:26], o_frame_word0[17:16]} == 4'h0)
		else $error("fault status nonzero");
	AST_SUPER: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_exc_active |-> o_status_register[`CEFU_SR_S] && !o_status_register[`CEFU_SR_T])
		else $error("entry status wrong");
	AST_NO_RESERVED: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_exc_active |-> !(o_vector inside {[8'h05:8'h07], 8'h0D, [8'h10:8'h17],
		[8'h30:8'h3F]}))
		else $error("reserved vector generated");
	AST_FLOW_DROP: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(i_flow_change && !i_fetch_err) |=> !fetch_fault_pending)
		else $error("discarded prefetch fault kept");
	AST_SYNC: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(i_no_operation_sync && i_write_pending) |=> o_sync_stall)
		else $error("sync did not stall");
	AST_INT_INHIBIT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_exc_active |-> !o_int_sample_en)
		else $error("interrupt sampled at handler entry");
	// Frame contents checked against the inputs of the taking cycle
	AST_PC_FAULT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(take && !map_next) |=> o_frame_word1 == $past(i_fault_pc))
		else $error("fault-type stacked counter wrong");
	AST_PC_NEXT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(take && map_next) |=> o_frame_word1 == $past(i_next_pc))
		else $error("next-type stacked counter wrong");
	AST_TRAP_VEC: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(take && sel_src == cefu_pkg::CEFU_SRC_TRAP)
		|=> o_vector == `CEFU_VEC_TRAP_BASE + {4'h0, $past(i_trap_num)})
		else $error("trap vector wrong");
	AST_AUTO_VEC: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(take_int && i_int_kind == cefu_pkg::CEFU_INT_AUTO && i_int_level != 3'h0)
		|=> o_vector == `CEFU_VEC_AUTO_BASE + {5'h00, $past(i_int_level)})
		else $error("autovector wrong");
	AST_INT_VEC: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(take_int && i_int_kind == cefu_pkg::CEFU_INT_VECTORED && i_int_vector >= `CEFU_VEC_USER_MIN)
		|=> o_vector == $past(i_int_vector))
		else $error("peripheral vector not used");
	AST_FRAME_SP: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		take |=> o_frame_sp == $past(i_stack_pointer_register) - `CEFU_FRAME_BYTES
		- {30'h0000_0000, $past(sp_low)})
		else $error("frame stack pointer wrong");
	AST_WPROT_CODE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(i_write_err && i_write_prot) |=> write_err_pending && write_err_fs == `CEFU_FS_WPROT)
		else $error("write-protect code not held");
	AST_READ_ABORT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(take && sel_src == cefu_pkg::CEFU_SRC_ACCESS && sel_fs == `CEFU_FS_READ)
		|=> o_abort && o_keep_addr_updates)
		else $error("read error did not abort");
	AST_FETCH_ABORT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(take && sel_src == cefu_pkg::CEFU_SRC_ACCESS && sel_fs == `CEFU_FS_FETCH)
		|=> o_abort && !o_keep_addr_updates)
		else $error("fetch error abort wrong");
	AST_WRITE_NO_ABORT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(take && (sel_fs == `CEFU_FS_WRITE || sel_fs == `CEFU_FS_WPROT))
		|=> !o_abort && !o_keep_addr_updates)
		else $error("write error aborted an instruction");
	AST_INT_MASK: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		take_int |=> o_status_register[`CEFU_SR_IMSK_HI:`CEFU_SR_IMSK_LO] == $past(i_int_level)
		&& !o_status_register[`CEFU_SR_M])
		else $error("interrupt entry mask wrong");
endmodule

// File: rtl/cefu_pkg.sv
// Types shared by the exception frame unit
package cefu_pkg;
	typedef enum logic [3:0] {
		CEFU_SRC_NONE,
		CEFU_SRC_ACCESS,
		CEFU_SRC_ADDRESS,
		CEFU_SRC_ILLEGAL,
		CEFU_SRC_PRIV,
		CEFU_SRC_TRACE,
		CEFU_SRC_LINE_A,
		CEFU_SRC_LINE_F,
		CEFU_SRC_DEBUG,
		CEFU_SRC_FORMAT,
		CEFU_SRC_TRAP,
		CEFU_SRC_INTR
	} cefu_src_t;
	typedef enum logic [1:0] {
		CEFU_INT_VECTORED,
		CEFU_INT_AUTO,
		CEFU_INT_UNINIT,
		CEFU_INT_SPURIOUS
	} cefu_int_kind_t;
endpackage

// File: rtl/cefu_vector_map.sv
// Exception source to vector number and stacked-counter choice
`timescale 1ns/1ps
`include "cefu_defines.svh"
module cefu_vector_map (
	input wire cefu_pkg::cefu_src_t i_src,
	input wire logic [3:0] i_trap_num,
	input wire logic [2:0] i_int_level,
	input wire cefu_pkg::cefu_int_kind_t i_int_kind,
	input wire logic [7:0] i_int_vector,
	output logic [7:0] o_vector,
	output logic o_use_next_pc,
	output logic o_fs_allowed
);
	always_comb begin
		o_vector = `CEFU_VEC_ACCESS;
		o_use_next_pc = 1'b0;
		o_fs_allowed = 1'b0;
		case (i_src)
			cefu_pkg::CEFU_SRC_ACCESS: begin
				o_vector = `CEFU_VEC_ACCESS;
				o_fs_allowed = 1'b1;
			end
			cefu_pkg::CEFU_SRC_ADDRESS: begin
				o_vector = `CEFU_VEC_ADDRESS;
				o_fs_allowed = 1'b1;
			end
			cefu_pkg::CEFU_SRC_ILLEGAL: o_vector = `CEFU_VEC_ILLEGAL;
			cefu_pkg::CEFU_SRC_PRIV: o_vector = `CEFU_VEC_PRIV;
			cefu_pkg::CEFU_SRC_LINE_A: o_vector = `CEFU_VEC_LINE_A;
			cefu_pkg::CEFU_SRC_LINE_F: o_vector = `CEFU_VEC_LINE_F;
			cefu_pkg::CEFU_SRC_FORMAT: o_vector = `CEFU_VEC_FORMAT;
			cefu_pkg::CEFU_SRC_TRACE: begin
				o_vector = `CEFU_VEC_TRACE;
				o_use_next_pc = 1'b1;
			end
			cefu_pkg::CEFU_SRC_DEBUG: begin
				o_vector = `CEFU_VEC_DEBUG;
				o_use_next_pc = 1'b1;
			end
			cefu_pkg::CEFU_SRC_TRAP: begin
				o_vector = `CEFU_VEC_TRAP_BASE | {4'h0, i_trap_num};
				o_use_next_pc = 1'b1;
			end
			cefu_pkg::CEFU_SRC_INTR: begin
				o_use_next_pc = 1'b1;
				case (i_int_kind)
					cefu_pkg::CEFU_INT_AUTO: begin
						// Level 0 is no request; fall back to spurious
						if (i_int_level == 3'h0) begin
							o_vector = `CEFU_VEC_SPURIOUS;
						end else begin
							o_vector = `CEFU_VEC_AUTO_BASE + {5'h00, i_int_level};
						end
					end
					cefu_pkg::CEFU_INT_UNINIT: o_vector = `CEFU_VEC_UNINIT;
					cefu_pkg::CEFU_INT_SPURIOUS: o_vector = `CEFU_VEC_SPURIOUS;
					default: begin
						// Peripheral value used as given; below user range is spurious
						if (i_int_vector < `CEFU_VEC_USER_MIN) begin
							o_vector = `CEFU_VEC_SPURIOUS;
						end else begin
							o_vector = i_int_vector;
						end
					end
				endcase
			end
			default: o_vector = `CEFU_VEC_ACCESS;
		endcase
	end
endmodule

// File: tb/cefu_exception_unit_test.sv
// Self-checking bench for the exception frame unit
`timescale 1ns/1ps
module cefu_exception_unit_test;
	logic i_sys_clk, i_rst, i_exc_req, i_int_req, i_vector_base_we, i_fetch_err, i_flow_change;
	logic i_exec_faulted, i_read_err, i_write_err, i_write_prot, i_write_pending;
	logic i_no_operation_sync, i_insn_done, cmd_int;
	cefu_pkg::cefu_src_t i_exc_src;
	cefu_pkg::cefu_int_kind_t i_int_kind;
	logic [3:0] i_trap_num, i_addr_fs;
	logic [2:0] i_int_level, cmd_err;
	logic [7:0] i_int_vector, cmd_vec, o_vector, v, ivec;
	logic [15:0] i_status_register, o_status_register;
	logic [31:0] i_fault_pc, i_next_pc, i_stack_pointer_register, i_vector_base_wdata, vbx;
	logic [31:0] o_vector_addr, o_frame_word0, o_frame_word1, o_frame_sp, o_vector_base;
	logic o_exc_active, o_abort, o_keep_addr_updates, o_int_sample_en, o_sync_stall;
	logic o_reset_fetch_sp, o_reset_fetch_pc;
	logic [7:0] vt [2:9] = '{8'h03, 8'h04, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0E};
	integer seed = 36677;
	int err_count = 0;
	int check_count = 0;
	cefu_exception_unit i_cefu_exception_unit (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
		.i_exc_req(i_exc_req), .i_exc_src(i_exc_src), .i_trap_num(i_trap_num),
		.i_addr_fs(i_addr_fs), .i_int_req(i_int_req), .i_int_level(i_int_level),
		.i_int_kind(i_int_kind), .i_int_vector(i_int_vector), .i_fault_pc(i_fault_pc),
		.i_next_pc(i_next_pc), .i_stack_pointer_register(i_stack_pointer_register),
		.i_status_register(i_status_register), .i_vector_base_wdata(i_vector_base_wdata),
		.i_vector_base_we(i_vector_base_we), .i_fetch_err(i_fetch_err),
		.i_flow_change(i_flow_change), .i_exec_faulted(i_exec_faulted),
		.i_read_err(i_read_err), .i_write_err(i_write_err), .i_write_prot(i_write_prot),
		.i_write_pending(i_write_pending), .i_no_operation_sync(i_no_operation_sync),
		.i_insn_done(i_insn_done), .o_exc_active(o_exc_active), .o_vector(o_vector),
		.o_vector_addr(o_vector_addr), .o_frame_word0(o_frame_word0),
		.o_frame_word1(o_frame_word1), .o_frame_sp(o_frame_sp),
		.o_status_register(o_status_register), .o_abort(o_abort),
		.o_keep_addr_updates(o_keep_addr_updates), .o_int_sample_en(o_int_sample_en),
		.o_sync_stall(o_sync_stall), .o_vector_base(o_vector_base),
		.o_reset_fetch_sp(o_reset_fetch_sp), .o_reset_fetch_pc(o_reset_fetch_pc));
	cefu_periph_model i_cefu_periph_model (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
		.i_cmd_int(cmd_int), .i_cmd_vec(cmd_vec), .i_cmd_err(cmd_err),
		.i_exc_active(o_exc_active), .o_int_req(i_int_req), .o_int_vector(i_int_vector),
		.o_fetch_err(i_fetch_err), .o_read_err(i_read_err), .o_write_err(i_write_err),
		.o_write_prot(i_write_prot));
	initial begin
		i_sys_clk = 1'b0;
		forever #25 i_sys_clk = ~i_sys_clk;
	end
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) begin
			@(negedge i_sys_clk);
			chk(o_exc_active, 1'b0);
		end
	endtask
	task automatic rnd();
		i_fault_pc = $random(seed);
		i_next_pc = i_fault_pc + 32'h0000_0002;
		i_stack_pointer_register = $random(seed);
		i_status_register = 16'($random(seed));
		i_addr_fs = 4'($random(seed));
	endtask
	task automatic err_pulse(input logic [2:0] c);
		cmd_err = c;
		@(negedge i_sys_clk);
		cmd_err = 3'h0;
	endtask
	task automatic hand_done();
		i_insn_done = 1'b1;
		@(negedge i_sys_clk);
		i_insn_done = 1'b0;
		chk(o_int_sample_en, 1'b1);
	endtask
	// Waits for entry, then checks the whole frame in the entry cycle
	task automatic run(input logic [7:0] ev, input logic [3:0] fs, input logic nxt,
		input logic intr, input logic [2:0] l);
		logic [15:0] s;
		int n;
		n = 0;
		while (o_exc_active !== 1'b1 && n < 20) begin
			@(negedge i_sys_clk);
			n++;
		end
		if (n == 20) begin
			chk(1'b0, 1'b1);
			results();
		end
		s = (i_status_register | 16'h2000) & 16'h7FFF;
		if (intr) begin
			s = {s[15:13], 1'b0, s[11], l, s[7:0]};
		end
		chk(o_vector, ev);
		chk(o_frame_word0, {4'h4 + {2'h0, i_stack_pointer_register[1:0]}, fs[3:2], ev,
			fs[1:0], i_status_register});
		chk(o_frame_word1, nxt ? i_next_pc : i_fault_pc);
		chk(o_frame_sp, {i_stack_pointer_register[31:2], 2'h0} - 32'h0000_0008);
		chk(o_vector_addr, vbx + {22'h0, ev, 2'h0});
		chk(o_status_register, s);
		chk(o_int_sample_en, 1'b0);
		i_exc_req = 1'b0;
		cmd_int = 1'b0;
		i_exec_faulted = 1'b0;
		i_no_operation_sync = 1'b0;
	endtask
	initial begin
		i_rst = 1'b1;
		{i_exc_req, i_vector_base_we, i_flow_change, i_exec_faulted, cmd_int} = '0;
		{i_write_pending, i_no_operation_sync, i_insn_done, cmd_err, cmd_vec} = '0;
		i_exc_src = cefu_pkg::CEFU_SRC_NONE;
		i_int_kind = cefu_pkg::CEFU_INT_VECTORED;
		{i_trap_num, i_int_level, i_vector_base_wdata} = '0;
		rnd();
		repeat (12) @(negedge i_sys_clk);
		i_rst = 1'b0;
		@(negedge i_sys_clk);
		chk(o_reset_fetch_sp, 1'b1);
		@(negedge i_sys_clk);
		chk(o_reset_fetch_pc, 1'b1);
		chk(o_reset_fetch_sp, 1'b0);
		i_vector_base_wdata = $random(seed);
		i_vector_base_we = 1'b1;
		vbx = i_vector_base_wdata & 32'hFFF0_0000;
		@(negedge i_sys_clk);
		i_vector_base_we = 1'b0;
		@(negedge i_sys_clk);
		chk(o_vector_base, vbx);
		$display("test reset done");
		for (int k = 2; k < 26; k++) begin
			rnd();
			i_exc_src = cefu_pkg::cefu_src_t'(k < 10 ? k : 10);
			i_trap_num = 4'(k - 10);
			i_exc_req = 1'b1;
			v = (k < 10) ? vt[k] : 8'h20 + {4'h0, i_trap_num};
			run(v, (k == 2) ? i_addr_fs : 4'h0, k == 5 || k == 8 || k > 9, 1'b0, 3'h0);
			hand_done();
		end
		$display("test internal vectors done");
		for (int j = 0; j < 5; j++) begin
			rnd();
			i_exc_src = cefu_pkg::CEFU_SRC_TRAP;
			i_trap_num = 4'h0;
			i_exc_req = 1'b1;
			run(8'h20, 4'h0, 1'b1, 1'b0, 3'h0);
			rnd();
			i_int_level = 3'($random(seed));
			if (i_int_level == 3'h0) begin
				i_int_level = 3'h7;
			end
			i_int_kind = cefu_pkg::cefu_int_kind_t'(j % 4);
			ivec = (j == 4) ? 8'h30 : 8'h40 | 8'($random(seed));
			cmd_vec = ivec;
			cmd_int = 1'b1;
			case (j % 4)
				0: v = (j == 4) ? 8'h18 : ivec;
				1: v = 8'h18 + {5'h0, i_int_level};
				2: v = 8'h0F;
				default: v = 8'h18;
			endcase
			idle(4);
			hand_done();
			run(v, 4'h0, 1'b1, 1'b1, i_int_level);
			hand_done();
		end
		$display("test interrupts done");
		rnd();
		err_pulse(3'h1);
		run(8'h02, 4'hC, 1'b0, 1'b0, 3'h0);
		chk(o_abort, 1'b1);
		chk(o_keep_addr_updates, 1'b1);
		hand_done();
		err_pulse(3'h2);
		i_flow_change = 1'b1;
		@(negedge i_sys_clk);
		i_flow_change = 1'b0;
		i_exec_faulted = 1'b1;
		idle(6);
		i_exec_faulted = 1'b0;
		rnd();
		err_pulse(3'h2);
		idle(3);
		i_exec_faulted = 1'b1;
		run(8'h02, 4'h4, 1'b0, 1'b0, 3'h0);
		chk(o_abort, 1'b1);
		chk(o_keep_addr_updates, 1'b0);
		hand_done();
		$display("test read and fetch errors done");
		rnd();
		i_write_pending = 1'b1;
		err_pulse(3'h3);
		i_no_operation_sync = 1'b1;
		repeat (3) begin
			@(negedge i_sys_clk);
			chk(o_sync_stall, 1'b1);
			chk(o_exc_active, 1'b0);
		end
		i_write_pending = 1'b0;
		run(8'h02, 4'h8, 1'b0, 1'b0, 3'h0);
		chk(o_abort, 1'b0);
		hand_done();
		rnd();
		err_pulse(3'h4);
		idle(2);
		i_insn_done = 1'b1;
		@(negedge i_sys_clk);
		i_insn_done = 1'b0;
		chk(o_exc_active, 1'b1);
		run(8'h02, 4'h9, 1'b0, 1'b0, 3'h0);
		hand_done();
		$display("test write errors done");
		results();
	end
endmodule

// File: tb/cefu_periph_model.sv
// Bus and interrupting peripheral model facing the exception frame unit
`timescale 1ns/1ps
module cefu_periph_model (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_cmd_int,
	input wire logic [7:0] i_cmd_vec,
	input wire logic [2:0] i_cmd_err,
	input wire logic i_exc_active,
	output logic o_int_req,
	output logic [7:0] o_int_vector,
	output logic o_fetch_err,
	output logic o_read_err,
	output logic o_write_err,
	output logic o_write_prot
);
	logic acked;
	logic req_seen;
	logic [7:0] last_vec;
	// Entry only counts as acknowledge if the request stood at the taking edge
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			req_seen <= 1'b0;
		end else begin
			req_seen <= o_int_req;
		end
	end
	// Request withdrawn once the core has entered exception processing
	always_ff @(posedge i_sys_clk) begin
		if (i_rst || !i_cmd_int) begin
			acked <= 1'b0;
		end else if (i_exc_active && req_seen) begin
			acked <= 1'b1;
		end
	end
	always_ff @(posedge i_sys_clk) begin
		if (o_int_req) begin
			last_vec <= o_int_vector;
		end
	end
	assign o_int_req = i_cmd_int && !acked;
	// Released vector lines show the inverse, never a stale value
	assign o_int_vector = o_int_req ? i_cmd_vec : ~last_vec;
	assign o_read_err = (i_cmd_err == 3'h1);
	assign o_fetch_err = (i_cmd_err == 3'h2);
	assign o_write_err = (i_cmd_err == 3'h3) || (i_cmd_err == 3'h4);
	assign o_write_prot = (i_cmd_err == 3'h4);
endmodule
